// >>> logic/wfs_pkg.sv
package wfs_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OLOOP = 8'h04;
    localparam logic [7:0] REG_DYN = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_TBL = 8'h10;
    // Control field positions
    localparam int C_RUN = 0;
    localparam int C_STOP = 1;
    localparam int C_SCEN = 2;
    localparam int C_ARMED = 3;
    localparam int C_TMODE = 4;
    localparam int C_OADV = 6;
    localparam int C_DYN = 8;
    localparam int C_STRIG = 9;
    localparam int C_SEVT = 10;
    localparam int C_NELEM = 12;
    // Table entry field positions
    localparam int T_LOOPS = 16;
    localparam int T_ADV = 24;
    // Sizes
    localparam int NE = 4;
    localparam int EW = 2;
    localparam int DAC_W = 14;
    // Mid-scale code: signed zero
    localparam logic [DAC_W-1:0] OFFSET_CODE = 14'h2000;
    // Least select-to-output latency in sync cycles
    localparam logic [8:0] DYN_DLY = 9'h100;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [7:0] ONE8 = 8'h01;

    typedef enum logic [1:0] {
        ADV_AUTO = 2'h0,
        ADV_COND = 2'h1,
        ADV_REP = 2'h2,
        ADV_SNGL = 2'h3
    } wfs_adv_e;

    typedef enum logic [1:0] {
        TM_CONT = 2'h0,
        TM_TRIG = 2'h1,
        TM_GATE = 2'h2
    } wfs_tmode_e;

    typedef enum logic [1:0] {
        OUT_OFFSET = 2'h0,
        OUT_PLAY = 2'h1,
        OUT_HOLD = 2'h2
    } wfs_kind_e;

    // Gray coded along program, wait, play, advance, hold
    typedef enum logic [2:0] {
        ST_PROG = 3'h0,
        ST_WAIT = 3'h1,
        ST_PLAY = 3'h3,
        ST_ADV = 3'h2,
        ST_HOLD = 3'h6
    } wfs_state_e;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } wfs_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } wfs_apb_rsp_s;

    typedef struct packed {
        wfs_adv_e adv;
        logic [7:0] loops;
        logic [15:0] len;
    } wfs_ent_s;

    typedef struct packed {
        wfs_kind_e kind;
        logic [EW-1:0] elem;
        logic [15:0] pos;
        logic [DAC_W-1:0] code;
    } wfs_play_s;
endpackage

// >>> logic/wfs_seq_ctrl.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module wfs_seq_ctrl (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire wfs_pkg::wfs_apb_req_s i_apb,
    output wfs_pkg::wfs_apb_rsp_s o_apb,
    input wire logic i_trig,
    input wire logic i_gate,
    input wire logic i_enable,
    input wire logic i_event,
    input wire logic i_dyn_load,
    input wire logic [wfs_pkg::EW-1:0] i_dyn_sel,
    output wfs_pkg::wfs_play_s o_play
);
    // Whole module state
    typedef struct packed {
        wfs_pkg::wfs_state_e st;
        wfs_pkg::wfs_ent_s [wfs_pkg::NE-1:0] tbl;
        logic armed;
        logic scen;
        wfs_pkg::wfs_tmode_e tmode;
        wfs_pkg::wfs_adv_e oadv;
        logic dyn;
        logic [wfs_pkg::EW-1:0] nelem;
        logic [15:0] oloops;
        logic [wfs_pkg::EW-1:0] elem;
        logic [15:0] pos;
        logic [7:0] eloop;
        logic [15:0] ocnt;
        logic ev;
        logic en_ok;
        logic tail;
        logic adv_out;
        logic trig_d;
        logic gate_d;
        logic evt_d;
        logic [wfs_pkg::EW-1:0] sel;
        logic sel_pend;
        logic [8:0] sel_cnt;
        logic [wfs_pkg::EW-1:0] sel_act;
        logic [31:0] prdata;
        wfs_pkg::wfs_play_s out;
    } wfs_st_s;

    wfs_st_s state_ff;
    wfs_st_s nxt_state;
    logic rst_meta_ff; // First reset stage, read only by second
    logic rst_b_ff; // Released reset used everywhere

    // Reset release through two flops
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_b_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_b_ff <= rst_meta_ff;
        end
    end

    // Bus decode; zero wait states
    logic wr_en;
    logic rd_setup;
    logic tbl_hit;
    logic map_hit;
    localparam int EWI = wfs_pkg::EW;
    localparam logic [7:0] ONE8_L = wfs_pkg::ONE8;
    localparam logic [15:0] ONE16_L = wfs_pkg::ONE16;
    localparam logic [EWI-1:0] EONE = 2'h1;
    logic [EWI-1:0] tbl_idx;
    assign wr_en = i_apb.psel & i_apb.penable & i_apb.pwrite;
    assign rd_setup = i_apb.psel & ~i_apb.penable;
    // Index widened so a full table of four still compares correctly
    assign tbl_hit = (i_apb.paddr[7:4] == wfs_pkg::REG_TBL[7:4])
        && ({1'b0, i_apb.paddr[3:2]} < 3'(wfs_pkg::NE));
    assign tbl_idx = i_apb.paddr[3:2];
    assign map_hit = tbl_hit || (i_apb.paddr == wfs_pkg::REG_CTRL) || (i_apb.paddr == wfs_pkg::REG_OLOOP)
        || (i_apb.paddr == wfs_pkg::REG_DYN) || (i_apb.paddr == wfs_pkg::REG_STAT);
    assign o_apb.pready = 1'b1;
    // Unmapped addresses answer with an error
    assign o_apb.pslverr = i_apb.psel & i_apb.penable & ~map_hit;
    assign o_apb.prdata = state_ff.prdata;
    assign o_play = state_ff.out;

    // Next-state logic
    always_comb begin
        wfs_st_s s;
        wfs_pkg::wfs_ent_s e;
        logic trig_r;
        logic gate_r;
        logic gate_f;
        logic evt_r;
        logic run;
        logic stop;
        logic consume;
        logic last_loop;
        logic last_elem;
        logic at_end;
        logic seq_end;
        logic restart;
        logic go_next;
        logic start_ok;
        s = state_ff;
        trig_r = 1'b0;
        evt_r = 1'b0;
        run = 1'b0;
        stop = 1'b0;
        consume = 1'b0;
        seq_end = 1'b0;
        restart = 1'b0;
        go_next = 1'b0;
        e = state_ff.tbl[state_ff.elem];
        gate_r = i_gate & ~state_ff.gate_d;
        gate_f = ~i_gate & state_ff.gate_d;
        last_loop = (state_ff.eloop + ONE8_L) >= e.loops;
        last_elem = state_ff.elem >= state_ff.nelem;
        at_end = (state_ff.pos + ONE16_L) >= e.len;
        // Armed start needs enable once; later changes ignored
        start_ok = ~state_ff.armed | state_ff.en_ok | i_enable;
        // Software trigger and event are ored with the pins
        if (wr_en && i_apb.paddr == wfs_pkg::REG_CTRL) begin
            trig_r = i_apb.pwdata[wfs_pkg::C_STRIG];
            evt_r = i_apb.pwdata[wfs_pkg::C_SEVT];
            run = i_apb.pwdata[wfs_pkg::C_RUN];
            stop = i_apb.pwdata[wfs_pkg::C_STOP];
        end
        trig_r = trig_r | (i_trig & ~state_ff.trig_d);
        evt_r = evt_r | (i_event & ~state_ff.evt_d);
        s.trig_d = i_trig;
        s.gate_d = i_gate;
        s.evt_d = i_event;

        // Register writes; configuration only while programming
        if (wr_en && state_ff.st == wfs_pkg::ST_PROG) begin
            if (i_apb.paddr == wfs_pkg::REG_CTRL) begin
                s.scen = i_apb.pwdata[wfs_pkg::C_SCEN];
                s.armed = i_apb.pwdata[wfs_pkg::C_ARMED];
                s.tmode = wfs_pkg::wfs_tmode_e'(i_apb.pwdata[wfs_pkg::C_TMODE +: 2]);
                s.oadv = wfs_pkg::wfs_adv_e'(i_apb.pwdata[wfs_pkg::C_OADV +: 2]);
                s.dyn = i_apb.pwdata[wfs_pkg::C_DYN];
                s.nelem = i_apb.pwdata[wfs_pkg::C_NELEM +: EWI];
            end
            if (i_apb.paddr == wfs_pkg::REG_OLOOP) begin
                s.oloops = i_apb.pwdata[15:0];
            end
            if (tbl_hit) begin
                s.tbl[tbl_idx] = wfs_pkg::wfs_ent_s'(i_apb.pwdata[25:0]);
            end
        end
        // Dynamic selection from software or the port
        if (wr_en && i_apb.paddr == wfs_pkg::REG_DYN) begin
            s.sel = i_apb.pwdata[EWI-1:0];
            s.sel_pend = 1'b1;
            s.sel_cnt = wfs_pkg::DYN_DLY;
        end else if (i_dyn_load) begin
            s.sel = i_dyn_sel;
            s.sel_pend = 1'b1;
            s.sel_cnt = wfs_pkg::DYN_DLY;
        end else if (state_ff.sel_pend) begin
            // Delay keeps the switch at least the minimum latency away
            if (state_ff.sel_cnt == 9'h000) begin
                s.sel_act = state_ff.sel;
                s.sel_pend = 1'b0;
            end else begin
                s.sel_cnt = state_ff.sel_cnt - 9'h001;
            end
        end

        // Playback sequencing
        case (state_ff.st)
            wfs_pkg::ST_PROG: begin
                if (run) begin
                    s.en_ok = 1'b0;
                    s.tail = 1'b0;
                    s.ocnt = 16'h0000;
                    s.st = wfs_pkg::ST_WAIT;
                    if (state_ff.tmode == wfs_pkg::TM_CONT) begin
                        restart = 1'b1;
                    end
                end
            end
            wfs_pkg::ST_WAIT, wfs_pkg::ST_HOLD: begin
                // Trigger or gate rise starts or restarts
                if (((state_ff.tmode == wfs_pkg::TM_TRIG && trig_r)
                    || (state_ff.tmode == wfs_pkg::TM_GATE && gate_r)) && start_ok) begin
                    s.en_ok = 1'b1;
                    s.tail = 1'b0;
                    s.ocnt = 16'h0000;
                    restart = 1'b1;
                end
            end
            wfs_pkg::ST_ADV: begin
                // Waiting for an advancement event
                if (state_ff.ev) begin
                    if (state_ff.adv_out) begin
                        consume = 1'b1;
                        if (state_ff.oadv == wfs_pkg::ADV_REP) begin
                            s.st = wfs_pkg::ST_HOLD;
                        end else begin
                            restart = 1'b1;
                        end
                    end else begin
                        // Element end is re-evaluated with the event
                        s.st = wfs_pkg::ST_PLAY;
                    end
                end
            end
            wfs_pkg::ST_PLAY: begin
                if (state_ff.armed && state_ff.tmode == wfs_pkg::TM_CONT && i_enable) begin
                    s.en_ok = 1'b1;
                end
                if (!at_end) begin
                    s.pos = state_ff.pos + ONE16_L;
                end else begin
                    s.pos = 16'h0000;
                    if (state_ff.dyn) begin
                        // Dynamic items run their own loops only
                        if (last_loop) begin
                            seq_end = 1'b1;
                        end else begin
                            s.eloop = state_ff.eloop + ONE8_L;
                        end
                    end else if (state_ff.armed && state_ff.tmode == wfs_pkg::TM_CONT
                        && state_ff.elem == '0 && !state_ff.en_ok) begin
                        // First element held until enable
                        s.eloop = 8'h00;
                    end else begin
                        case (e.adv)
                            wfs_pkg::ADV_AUTO: begin
                                go_next = last_loop;
                            end
                            wfs_pkg::ADV_COND: begin
                                go_next = state_ff.ev;
                                consume = state_ff.ev;
                            end
                            wfs_pkg::ADV_REP: begin
                                go_next = last_loop & state_ff.ev;
                                consume = go_next;
                            end
                            default: begin
                                consume = state_ff.ev;
                                go_next = last_loop & state_ff.ev;
                            end
                        endcase
                        // Hold the last sample while an event is owed
                        if ((e.adv == wfs_pkg::ADV_SNGL || (e.adv == wfs_pkg::ADV_REP && last_loop))
                            && !state_ff.ev) begin
                            s.st = wfs_pkg::ST_ADV;
                            s.adv_out = 1'b0;
                            s.pos = state_ff.pos;
                        end else if (go_next) begin
                            s.eloop = 8'h00;
                            if (last_elem) begin
                                seq_end = 1'b1;
                            end else begin
                                s.elem = state_ff.elem + EONE;
                            end
                        end else if (e.adv != wfs_pkg::ADV_COND) begin
                            s.eloop = state_ff.eloop + ONE8_L;
                        end
                    end
                end
                // Outer level: whole sequence, or the dynamic item in dynamic mode
                if (seq_end) begin
                    s.ocnt = state_ff.ocnt + ONE16_L;
                    if (state_ff.tmode == wfs_pkg::TM_CONT) begin
                        restart = 1'b1;
                    end else if (state_ff.tmode == wfs_pkg::TM_GATE) begin
                        // Pass cut by the fall does not count
                        if (state_ff.tail && s.ocnt > state_ff.oloops) begin
                            s.st = wfs_pkg::ST_HOLD;
                            s.pos = state_ff.pos;
                        end else begin
                            restart = 1'b1;
                        end
                    end else if (state_ff.dyn) begin
                        s.st = wfs_pkg::ST_HOLD;
                        s.pos = state_ff.pos;
                    end else begin
                        case (state_ff.oadv)
                            wfs_pkg::ADV_AUTO: begin
                                restart = s.ocnt < state_ff.oloops;
                                s.st = restart ? wfs_pkg::ST_PLAY : wfs_pkg::ST_HOLD;
                            end
                            wfs_pkg::ADV_REP: begin
                                restart = s.ocnt < state_ff.oloops;
                                s.st = restart ? wfs_pkg::ST_PLAY : wfs_pkg::ST_ADV;
                                s.adv_out = 1'b1;
                            end
                            wfs_pkg::ADV_SNGL: begin
                                s.st = (s.ocnt < state_ff.oloops) ? wfs_pkg::ST_ADV : wfs_pkg::ST_HOLD;
                                s.adv_out = 1'b1;
                            end
                            default: begin
                                restart = 1'b1;
                            end
                        endcase
                        if (!restart) begin
                            s.pos = state_ff.pos;
                        end
                    end
                end
                // Fall handled after the pass end, so both in one cycle count right
                if (gate_f && state_ff.tmode == wfs_pkg::TM_GATE && !state_ff.tail) begin
                    s.tail = 1'b1;
                    s.ocnt = seq_end ? ONE16_L : 16'h0000;
                end
            end
            default: begin
                s.st = wfs_pkg::ST_PROG;
            end
        endcase

        // Begin element 0, or the selected item in dynamic mode, from its first sample
        if (restart) begin
            s.st = wfs_pkg::ST_PLAY;
            s.pos = 16'h0000;
            s.eloop = 8'h00;
            s.elem = state_ff.dyn ? s.sel_act : '0;
        end
        // Stop aborts at once, whatever is playing
        if (stop) begin
            s.st = wfs_pkg::ST_PROG;
            s.pos = 16'h0000;
            s.elem = '0;
        end
        // Event latch; a new event wins over the consume
        s.ev = (state_ff.ev & ~consume) | evt_r;

        // Registered output view
        case (s.st)
            wfs_pkg::ST_PLAY: s.out.kind = wfs_pkg::OUT_PLAY;
            wfs_pkg::ST_ADV, wfs_pkg::ST_HOLD: s.out.kind = wfs_pkg::OUT_HOLD;
            default: s.out.kind = wfs_pkg::OUT_OFFSET;
        endcase
        s.out.elem = s.elem;
        s.out.pos = s.pos;
        s.out.code = wfs_pkg::OFFSET_CODE;

        // Read data captured in the setup phase
        if (rd_setup) begin
            s.prdata = 32'h0000_0000;
            case (i_apb.paddr)
                wfs_pkg::REG_CTRL: begin
                    s.prdata[wfs_pkg::C_SCEN] = state_ff.scen;
                    s.prdata[wfs_pkg::C_ARMED] = state_ff.armed;
                    s.prdata[wfs_pkg::C_TMODE +: 2] = state_ff.tmode;
                    s.prdata[wfs_pkg::C_OADV +: 2] = state_ff.oadv;
                    s.prdata[wfs_pkg::C_DYN] = state_ff.dyn;
                    s.prdata[wfs_pkg::C_NELEM +: EWI] = state_ff.nelem;
                end
                wfs_pkg::REG_OLOOP: s.prdata[15:0] = state_ff.oloops;
                wfs_pkg::REG_DYN: s.prdata[EWI-1:0] = state_ff.sel_act;
                wfs_pkg::REG_STAT: s.prdata = {state_ff.ocnt, 5'h00, state_ff.ev, state_ff.en_ok,
                    state_ff.elem, 4'h0, state_ff.st};
                default: begin
                    if (tbl_hit) begin
                        s.prdata[25:0] = state_ff.tbl[tbl_idx];
                    end
                end
            endcase
        end
        nxt_state = s;
    end

    // Reset gives programming mode with offset out
    always_ff @(posedge i_clk or negedge rst_b_ff) begin
        if (!rst_b_ff) begin
            state_ff <= '0;
            state_ff.out.code <= wfs_pkg::OFFSET_CODE;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

// >>> sim/wfs_seq_ctrl_chk.sv
`timescale 1ns/1ps
module wfs_seq_ctrl_chk (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire wfs_pkg::wfs_apb_req_s i_apb,
    input wire wfs_pkg::wfs_apb_rsp_s o_apb,
    input wire logic i_trig,
    input wire logic i_gate,
    input wire logic i_enable,
    input wire logic i_event,
    input wire logic i_dyn_load,
    input wire logic [wfs_pkg::EW-1:0] i_dyn_sel,
    input wire wfs_pkg::wfs_play_s o_play
);
    localparam int DLY = 256;
    // Mode copy follows every control write, ignored ones too
    logic [1:0] tm_ff;
    logic arm_ff;
    logic dyn_ff;
    logic en_ff;
    logic [8:0] cnt_ff;
    logic [wfs_pkg::EW-1:0] sel_ff;
    wire logic wr_ctl = i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.paddr == wfs_pkg::REG_CTRL;
    wire logic play = o_play.kind == wfs_pkg::OUT_PLAY;
    // Helper state: mode, enable seen, cycles since selection
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tm_ff <= 2'h0;
            arm_ff <= 1'b0;
            dyn_ff <= 1'b0;
            en_ff <= 1'b0;
            cnt_ff <= 9'h000;
            sel_ff <= '0;
        end else begin
            if (wr_ctl) begin
                tm_ff <= i_apb.pwdata[wfs_pkg::C_TMODE +: 2];
                arm_ff <= i_apb.pwdata[wfs_pkg::C_ARMED];
                dyn_ff <= i_apb.pwdata[wfs_pkg::C_DYN];
            end
            // Cleared on stop or reprogramming, so a restart needs a fresh enable
            en_ff <= wr_ctl ? 1'b0 : (en_ff || i_enable);
            if (i_dyn_load) begin
                cnt_ff <= 9'h000;
                sel_ff <= i_dyn_sel;
            end else if (cnt_ff != 9'h1FF) begin
                cnt_ff <= cnt_ff + 9'h001;
            end
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_offset_code: assert property (o_play.code == wfs_pkg::OFFSET_CODE)
        else $error("offset code wrong");
    a_trig_start: assert property (tm_ff == 2'h1 && play && $past(o_play.kind) == wfs_pkg::OUT_OFFSET
        |-> $past(i_trig) && !$past(i_trig, 2)) else $error("start without trigger");
    a_gate_start: assert property (tm_ff == 2'h2 && play && $past(o_play.kind) == wfs_pkg::OUT_OFFSET
        |-> $past(i_gate) && !$past(i_gate, 2)) else $error("start without gate edge");
    a_cont_start: assert property (wr_ctl && i_apb.pwdata[wfs_pkg::C_RUN]
        && i_apb.pwdata[wfs_pkg::C_TMODE +: 2] == 2'h0 |-> ##[1:3] play) else $error("no autostart");
    a_stop_abort: assert property (wr_ctl && i_apb.pwdata[wfs_pkg::C_STOP]
        |-> ##[1:2] o_play.kind == wfs_pkg::OUT_OFFSET) else $error("stop not immediate");
    a_pos_step: assert property (play && $past(play)
        |-> o_play.pos == $past(o_play.pos) + 16'h0001 || o_play.pos == 16'h0000) else $error("position jump");
    a_armed_hold: assert property (arm_ff && tm_ff == 2'h0 && $past(o_play.elem) == '0
        && o_play.elem != '0 |-> en_ff) else $error("left first element without enable");
    a_dyn_delay: assert property (dyn_ff && play && o_play.elem == sel_ff
        && $past(o_play.elem) != sel_ff |-> cnt_ff >= DLY) else $error("selection too early");
    c_hold: cover property (o_play.kind == wfs_pkg::OUT_HOLD);
    c_load: cover property (i_dyn_load);
    c_stop: cover property (wr_ctl && i_apb.pwdata[wfs_pkg::C_STOP]);
endmodule
bind wfs_seq_ctrl wfs_seq_ctrl_chk i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(i_apb), .o_apb(o_apb),
    .i_trig(i_trig), .i_gate(i_gate), .i_enable(i_enable), .i_event(i_event), .i_dyn_load(i_dyn_load),
    .i_dyn_sel(i_dyn_sel), .o_play(o_play));

// >>> sim/wfs_src.sv
`timescale 1ns/1ps
module wfs_src (
    input wire logic i_clk,
    input wire logic [2:0] i_pulse, // Trigger, event, load requests
    input wire logic i_gate_lvl,
    input wire logic i_en_lvl,
    input wire logic [wfs_pkg::EW-1:0] i_sel,
    output logic o_trig,
    output logic o_event,
    output logic o_load,
    output logic o_gate,
    output logic o_enable,
    output logic [wfs_pkg::EW-1:0] o_sel
);
    // Registered sources; select line toggles when not loading
    always_ff @(posedge i_clk) begin
        o_trig <= i_pulse[0];
        o_event <= i_pulse[1];
        o_load <= i_pulse[2];
        o_sel <= i_pulse[2] ? i_sel : ~o_sel;
        o_gate <= i_gate_lvl;
        o_enable <= i_en_lvl;
    end
endmodule

// >>> sim/wfs_seq_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; $display("FAIL %0t got %0h exp %0h", $time, a, e); end end
module wfs_seq_ctrl_tb;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    wfs_pkg::wfs_apb_req_s apb = '0;
    wfs_pkg::wfs_apb_rsp_s rsp;
    wfs_pkg::wfs_play_s play;
    logic [2:0] pulse = 3'h0;
    logic gate = 1'b0;
    logic en = 1'b0;
    logic [1:0] sel = 2'h0;
    logic trig, evt, load, gt, ena;
    logic [1:0] dsel;
    logic peek = 1'b0;
    logic [63:0] exp_q[$]; // Mask and value notes
    logic [63:0] ex;
    logic [31:0] obs;
    int errors = 0;
    int checks_done = 0;
    int n;
    int len;
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    wfs_seq_ctrl i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_apb(apb), .o_apb(rsp), .i_trig(trig),
        .i_gate(gt), .i_enable(ena), .i_event(evt), .i_dyn_load(load), .i_dyn_sel(dsel), .o_play(play));
    wfs_src i_src (.i_clk(i_clk), .i_pulse(pulse), .i_gate_lvl(gate), .i_en_lvl(en), .i_sel(sel),
        .o_trig(trig), .o_event(evt), .o_load(load), .o_gate(gt), .o_enable(ena), .o_sel(dsel));
    // Mid-cycle compare, away from the edges
    always @(negedge i_clk) begin
        if ((apb.psel && apb.penable && !apb.pwrite) || peek) begin
            obs = peek ? {28'h0, play.elem, play.kind} : rsp.prdata;
            ex = exp_q.pop_front();
            `CHK(obs & ex[63:32], ex[31:0])
        end
    end
    task automatic test_done();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic tmo();
        errors++;
        $display("FAIL %0t wait expired", $time);
        test_done();
    endtask
    // One APB transfer, held until pready
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge i_clk);
        apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge i_clk);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        if (k >= 50) tmo();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        exp_q.push_back({m, v});
        xfer(a, 1'b0, 32'h0);
    endtask
    // Note expected element and kind, then sample once
    task automatic look(input logic [3:0] v);
        exp_q.push_back({32'hF, 28'h0, v});
        @(posedge i_clk);
        peek <= 1'b1;
        @(posedge i_clk);
        peek <= 1'b0;
    endtask
    task automatic wt(input logic [3:0] v, input int lim);
        n = 0;
        while ({play.elem, play.kind} !== v) begin
            @(negedge i_clk);
            n++;
            if (n > lim) tmo();
        end
    endtask
    task automatic pls(input int b);
        @(posedge i_clk);
        pulse[b] <= 1'b1;
        @(posedge i_clk);
        pulse[b] <= 1'b0;
    endtask
    function automatic logic [31:0] cw(logic [1:0] tm, logic [1:0] adv, logic arm, logic dyn, logic [1:0] last);
        return {18'h0, last, 3'h0, dyn, adv, tm, arm, 3'h0};
    endfunction
    // Stop, outer loops, config, then run
    task automatic cfg(input logic [31:0] c, input logic [15:0] ol);
        xfer(wfs_pkg::REG_CTRL, 1'b1, 32'h2);
        xfer(wfs_pkg::REG_OLOOP, 1'b1, {16'h0, ol});
        xfer(wfs_pkg::REG_CTRL, 1'b1, c);
        xfer(wfs_pkg::REG_CTRL, 1'b1, c | 32'h1);
    endtask
    initial begin
        void'($urandom(55));
        repeat (10) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd(wfs_pkg::REG_STAT, 32'h7, 32'h0);
        look(4'h0);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        len = 2 + $urandom % 6;
        xfer(wfs_pkg::REG_TBL, 1'b1, {8'h0, 8'h03, 16'(len)});
        xfer(wfs_pkg::REG_TBL + 8'h04, 1'b1, {8'h0, 8'h01, 16'(len)});
        // Triggered, auto: offset until trigger, then one pass of three loops
        cfg(cw(2'h1, 2'h0, 1'b0, 1'b0, 2'h0), 16'h1);
        repeat (20) @(posedge i_clk);
        look(4'h0);
        pls(0);
        wt(4'h1, 20);
        wt(4'h2, 100);
        `CHK(n, 3 * len)
        // Single outer: event needed before the next pass
        cfg(cw(2'h1, 2'h3, 1'b0, 1'b0, 2'h0), 16'h2);
        pls(0);
        wt(4'h1, 20);
        wt(4'h2, 100);
        repeat (20) @(posedge i_clk);
        look(4'h2);
        pls(1);
        wt(4'h1, 20);
        wt(4'h2, 100);
        `CHK(n, 3 * len)
        // Repeat outer: after the loops, wait for the event, then hold
        cfg(cw(2'h1, 2'h2, 1'b0, 1'b0, 2'h0), 16'h1);
        pls(0);
        wt(4'h2, 100);
        rd(wfs_pkg::REG_STAT, 32'h7, 32'h2);
        pls(1);
        repeat (3) @(posedge i_clk);
        rd(wfs_pkg::REG_STAT, 32'h7, 32'h6);
        // Gated: loops while high, finishes after the fall
        cfg(cw(2'h2, 2'h0, 1'b0, 1'b0, 2'h0), 16'h1);
        @(posedge i_clk) gate <= 1'b1;
        wt(4'h1, 20);
        repeat (50) @(posedge i_clk);
        look(4'h1);
        @(posedge i_clk) gate <= 1'b0;
        wt(4'h2, 8 * len);
        `CHK(n > 3 * len && n <= 6 * len + 2, 1'b1)
        // Armed continuous: first element holds until enable
        cfg(cw(2'h0, 2'h0, 1'b1, 1'b0, 2'h1), 16'h1);
        repeat (60) @(posedge i_clk);
        look(4'h1);
        @(posedge i_clk) en <= 1'b1;
        wt(4'h5, 200);
        @(posedge i_clk) en <= 1'b0;
        xfer(wfs_pkg::REG_CTRL, 1'b1, 32'h2);
        look(4'h0);
        cfg(cw(2'h0, 2'h0, 1'b1, 1'b0, 2'h1), 16'h1);
        repeat (60) @(posedge i_clk);
        look(4'h1);
        @(posedge i_clk) en <= 1'b1;
        wt(4'h5, 200);
        @(posedge i_clk) en <= 1'b0;
        // Dynamic continuous, not armed and auto everywhere
        cfg(cw(2'h0, 2'h0, 1'b0, 1'b1, 2'h1), 16'h1);
        wt(4'h1, 20);
        sel <= 2'h1;
        pls(2);
        wt(4'h5, 1000);
        `CHK(n >= 256, 1'b1)
        look(4'h5);
        test_done();
    end
endmodule
